/* logic/sdm_pkg.sv */
package sdm_pkg;
   localparam logic [15:0] ADDR_SCRATCH = 16'h000D;
   localparam logic [15:0] ADDR_MASK_CLEAR = 16'h000E;
   localparam logic [15:0] ADDR_MASK_GROUP = 16'h000F;
   localparam logic [15:0] ADDR_SINGLE_MASK = 16'h000A;
   localparam logic [15:0] ADDR_POST = 16'h0080;
   localparam logic [15:0] ADDR_PAGE2 = 16'h0081;
   localparam logic [15:0] ADDR_PAGE3 = 16'h0082;
   localparam logic [15:0] ADDR_PAGE1 = 16'h0083;
   localparam logic [3:0] MASK_RESET = 4'hF;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam int SINGLE_SEL_LSB = 0;
   localparam int SINGLE_SET_BIT = 2;
   localparam int CHANNELS = 4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } sdm_io_s;

   typedef struct packed {
      logic [15:0] mem_addr;
      logic [3:0] ext_page;
   } sdm_addr_src_s;
endpackage : sdm_pkg

/* logic/sdm_mask_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module sdm_mask_bank (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic group_wr_i,
   input wire logic single_wr_i,
   input wire logic [7:0] wdata_i,
   output logic [3:0] mask_o
);
   import sdm_pkg::*;
   logic [3:0] mask;
   logic [3:0] next_mask;

   // One shared set for all three ports
   always_comb begin
      next_mask = mask;
      if (clear_i) begin
         next_mask = 4'h0;
      end else if (group_wr_i) begin
         next_mask = wdata_i[3:0];
      end else if (single_wr_i) begin
         next_mask[wdata_i[SINGLE_SEL_LSB +: 2]] = wdata_i[SINGLE_SET_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mask <= MASK_RESET;
      end else begin
         mask <= next_mask;
      end
   end

   assign mask_o = mask;
endmodule : sdm_mask_bank
`default_nettype wire

/* logic/sdm_page_addr.sv */
`timescale 1ns/1ps
`default_nettype none
module sdm_page_addr (
   input wire logic [7:0] page_i,
   input wire sdm_pkg::sdm_addr_src_s src_i,
   input wire logic wide_i,
   output logic [27:0] addr_o
);
   import sdm_pkg::*;
   // Wide transfers take bit 16 from the address register, page bit 0 ignored
   always_comb begin
      addr_o = {src_i.ext_page, page_i, src_i.mem_addr};
      if (wide_i) begin
         addr_o = {src_i.ext_page, page_i[7:1], src_i.mem_addr[0], src_i.mem_addr[15:1], 1'b0};
      end
   end
endmodule : sdm_page_addr
`default_nettype wire

/* logic/sdm_regs.sv */
// How it works
// - Scratch byte at 000Dh, no transfer role
// - No memory-to-memory transfer path exists
// - Mask clear write enables all channels
// - Group mask 000Fh bits 3:0, 1 blocks
// - One shared mask set for all ports
// - 0080h write stores and forwards to GP
// - 0080h read returns byte, no GP cycle
// - 0080h is no page register
// - Pages 81/82/83 for channels 2/3/1
// - Page, address, extended page form 28 bits
// - Channel 3 wide: page 7:1 to 23:17
// - Channel 3 page bit 0 still reads back
// - Channel 3 wide only with enhanced mode
// - Enhanced mode: channel 3 page advances at boundaries
// - Write 000Dh resets slave controller
`timescale 1ns/1ps
`default_nettype none
module sdm_regs (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire sdm_pkg::sdm_io_s io_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic gp_wr_o,
   output logic [15:0] gp_addr_o,
   output logic [7:0] gp_data_o,
   output logic [3:0] chan_mask_o,
   output logic slave_clear_o,
   input wire sdm_pkg::sdm_addr_src_s ch1_src_i,
   input wire sdm_pkg::sdm_addr_src_s ch2_src_i,
   input wire sdm_pkg::sdm_addr_src_s ch3_src_i,
   input wire logic enhanced_feature_on_i,
   input wire logic chan3_wide_select_i,
   input wire logic page_step_i,
   output logic [27:0] ch1_addr_o,
   output logic [27:0] ch2_addr_o,
   output logic [27:0] ch3_addr_o
);
   import sdm_pkg::*;

   logic [7:0] scratch_byte_field;
   logic [7:0] post_code_byte;
   logic [7:0] chan1_page_bits;
   logic [7:0] chan2_page_bits;
   logic [7:0] chan3_page_bits;
   logic [7:0] next_scratch;
   logic [7:0] next_post;
   logic [7:0] next_pg1;
   logic [7:0] next_pg2;
   logic [7:0] next_pg3;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic rvalid;
   logic next_rvalid;
   logic gp_wr;
   logic next_gp_wr;
   logic [7:0] gp_data;
   logic [7:0] next_gp_data;
   logic slave_clear;
   logic wr_scratch;
   logic wr_clear;
   logic wr_group;
   logic wr_single;
   logic wr_post;
   logic wr_pg1;
   logic wr_pg2;
   logic wr_pg3;
   logic chan3_wide;
   logic [3:0] mask;
   logic [27:0] a1;
   logic [27:0] a2;
   logic [27:0] a3;
   logic [27:0] ch1_addr;
   logic [27:0] ch2_addr;
   logic [27:0] ch3_addr;

   assign wr_scratch = io_i.wr && io_i.addr == ADDR_SCRATCH;
   assign wr_clear = io_i.wr && io_i.addr == ADDR_MASK_CLEAR;
   assign wr_group = io_i.wr && io_i.addr == ADDR_MASK_GROUP;
   assign wr_single = io_i.wr && io_i.addr == ADDR_SINGLE_MASK;
   assign wr_post = io_i.wr && io_i.addr == ADDR_POST;
   assign wr_pg2 = io_i.wr && io_i.addr == ADDR_PAGE2;
   assign wr_pg3 = io_i.wr && io_i.addr == ADDR_PAGE3;
   assign wr_pg1 = io_i.wr && io_i.addr == ADDR_PAGE1;

   // Narrow unless enhanced mode permits the wide size
   assign chan3_wide = enhanced_feature_on_i && chan3_wide_select_i;

   sdm_mask_bank u_mask (
      .clk_i(clk_i),
      .reset_i(reset_i || slave_clear),
      .clear_i(wr_clear),
      .group_wr_i(wr_group),
      .single_wr_i(wr_single),
      .wdata_i(io_i.wdata),
      .mask_o(mask)
   );

   // Page state; the scratch byte survives the controller clear on purpose,
   // since the clear and the scratch share one address
   always_comb begin
      next_scratch = scratch_byte_field;
      next_post = post_code_byte;
      next_pg1 = chan1_page_bits;
      next_pg2 = chan2_page_bits;
      next_pg3 = chan3_page_bits;
      if (wr_scratch) begin
         next_scratch = io_i.wdata;
      end
      if (wr_post) begin
         next_post = io_i.wdata;
      end
      if (wr_pg1) begin
         next_pg1 = io_i.wdata;
      end
      if (wr_pg2) begin
         next_pg2 = io_i.wdata;
      end
      if (wr_pg3) begin
         next_pg3 = io_i.wdata;
      end else if (enhanced_feature_on_i && page_step_i) begin
         // Carry into the page at a 64K or 128K wrap
         if (chan3_wide) begin
            next_pg3 = {chan3_page_bits[7:1] + 7'h01, chan3_page_bits[0]};
         end else begin
            next_pg3 = chan3_page_bits + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         scratch_byte_field <= BYTE_RESET;
         post_code_byte <= BYTE_RESET;
         chan1_page_bits <= BYTE_RESET;
         chan2_page_bits <= BYTE_RESET;
         chan3_page_bits <= BYTE_RESET;
      end else begin
         scratch_byte_field <= next_scratch;
         post_code_byte <= next_post;
         chan1_page_bits <= next_pg1;
         chan2_page_bits <= next_pg2;
         chan3_page_bits <= next_pg3;
      end
   end

   // Read mux and GP forwarding; reads never touch the GP bus
   always_comb begin
      next_rdata = 8'h00;
      next_rvalid = io_i.rd;
      next_gp_wr = wr_post;
      next_gp_data = wr_post ? io_i.wdata : gp_data;
      if (io_i.rd) begin
         case (io_i.addr)
            ADDR_SCRATCH: next_rdata = scratch_byte_field;
            ADDR_POST: next_rdata = post_code_byte;
            ADDR_PAGE1: next_rdata = chan1_page_bits;
            ADDR_PAGE2: next_rdata = chan2_page_bits;
            ADDR_PAGE3: next_rdata = chan3_page_bits;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata <= BYTE_RESET;
         rvalid <= 1'b0;
         gp_wr <= 1'b0;
         gp_data <= BYTE_RESET;
         slave_clear <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
         gp_wr <= next_gp_wr;
         gp_data <= next_gp_data;
         slave_clear <= wr_scratch;
      end
   end

   // Only channels 1..3 get an address; 0080h feeds no channel
   sdm_page_addr u_a1 (.page_i(chan1_page_bits), .src_i(ch1_src_i), .wide_i(1'b0),
      .addr_o(a1));
   sdm_page_addr u_a2 (.page_i(chan2_page_bits), .src_i(ch2_src_i), .wide_i(1'b0),
      .addr_o(a2));
   sdm_page_addr u_a3 (.page_i(chan3_page_bits), .src_i(ch3_src_i), .wide_i(chan3_wide),
      .addr_o(a3));

   // Memory-to-memory is absent: each address pairs one channel with memory
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ch1_addr <= 28'h000_0000;
         ch2_addr <= 28'h000_0000;
         ch3_addr <= 28'h000_0000;
      end else begin
         ch1_addr <= a1;
         ch2_addr <= a2;
         ch3_addr <= a3;
      end
   end

   assign rdata_o = rdata;
   assign rvalid_o = rvalid;
   assign gp_wr_o = gp_wr;
   assign gp_addr_o = ADDR_POST;
   assign gp_data_o = gp_data;
   assign chan_mask_o = mask;
   assign slave_clear_o = slave_clear;
   assign ch1_addr_o = ch1_addr;
   assign ch2_addr_o = ch2_addr;
   assign ch3_addr_o = ch3_addr;

   // Checks watch what this block drives to the bus and channels, and its scratch, post and page registers
   a_mask_clear: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_clear && !slave_clear |=> chan_mask_o == 4'h0)
      else $error("mask clear failed");
   a_group_mask: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_group && !wr_clear && !slave_clear |=> chan_mask_o == $past(io_i.wdata[3:0]))
      else $error("group mask wrong");
   a_single_mask: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_single && !slave_clear |=> chan_mask_o[$past(io_i.wdata[1:0])] == $past(io_i.wdata[2]))
      else $error("single mask wrong");
   a_mask_hold: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !wr_clear && !wr_group && !wr_single && !slave_clear |=> $stable(chan_mask_o))
      else $error("mask changed unasked");
   a_post_fwd: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_post |=> gp_wr_o && gp_data_o == $past(io_i.wdata))
      else $error("no GP forward");
   a_gp_only_post: assert property (
      @(posedge clk_i) disable iff (reset_i)
      gp_wr_o |-> $past(wr_post))
      else $error("GP cycle without post write");
   a_read_nogp: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd && !io_i.wr |=> !gp_wr_o)
      else $error("read made GP cycle");
   a_post_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd && io_i.addr == ADDR_POST && !wr_post |=> rdata_o == post_code_byte)
      else $error("post read wrong");
   a_read_valid: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd |=> rvalid_o)
      else $error("read not answered");
   a_scratch_store: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_scratch |=> scratch_byte_field == $past(io_i.wdata))
      else $error("scratch not stored");
   a_scratch_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd && io_i.addr == ADDR_SCRATCH && !wr_scratch
      |=> rdata_o == $past(scratch_byte_field))
      else $error("scratch read wrong");
   a_clear_reset: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_scratch |=> slave_clear_o ##1 chan_mask_o == MASK_RESET)
      else $error("no reset");
   a_clear_pulse: assert property (
      @(posedge clk_i) disable iff (reset_i)
      slave_clear_o |-> $past(wr_scratch))
      else $error("clear without scratch write");
   a_read_zero: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd && io_i.addr == ADDR_MASK_GROUP |=> rdata_o == 8'h00)
      else $error("write-only mask read back");
   a_page1_write: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_pg1 |=> chan1_page_bits == $past(io_i.wdata))
      else $error("page 1 not stored");
   a_page2_write: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_pg2 |=> chan2_page_bits == $past(io_i.wdata))
      else $error("page 2 not stored");
   a_page3_write: assert property (
      @(posedge clk_i) disable iff (reset_i)
      wr_pg3 |=> chan3_page_bits == $past(io_i.wdata))
      else $error("page 3 not stored");
   a_page3_read: assert property (
      @(posedge clk_i) disable iff (reset_i)
      io_i.rd && io_i.addr == ADDR_PAGE3 |=> rdata_o == $past(chan3_page_bits))
      else $error("page 3 read wrong");
   a_ch1_addr: assert property (
      @(posedge clk_i) disable iff (reset_i)
      1'b1 |=> ch1_addr_o[23:16] == $past(chan1_page_bits))
      else $error("channel 1 page not in address");
   a_narrow_page: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !enhanced_feature_on_i |=> ch3_addr_o[23:16] == $past(chan3_page_bits))
      else $error("wide without enhanced");
   a_wide_bit16: assert property (
      @(posedge clk_i) disable iff (reset_i)
      chan3_wide |=> ch3_addr_o[16] == $past(ch3_src_i.mem_addr[0]))
      else $error("bit16 src");
   a_wide_page: assert property (
      @(posedge clk_i) disable iff (reset_i)
      chan3_wide |=> ch3_addr_o[23:17] == $past(chan3_page_bits[7:1]))
      else $error("wide page bits wrong");
   a_page_step: assert property (
      @(posedge clk_i) disable iff (reset_i)
      enhanced_feature_on_i && page_step_i && !wr_pg3 && !chan3_wide
      |=> chan3_page_bits == $past(chan3_page_bits) + 8'h01)
      else $error("page no step");
   a_wide_step: assert property (
      @(posedge clk_i) disable iff (reset_i)
      enhanced_feature_on_i && page_step_i && !wr_pg3 && chan3_wide
      |=> chan3_page_bits == {$past(chan3_page_bits[7:1]) + 7'h01, $past(chan3_page_bits[0])})
      else $error("wide page no step");
   a_no_step: assert property (
      @(posedge clk_i) disable iff (reset_i)
      !enhanced_feature_on_i && !wr_pg3 |=> $stable(chan3_page_bits))
      else $error("page stepped outside enhanced mode");
endmodule : sdm_regs
`default_nettype wire

/* testbench/sdm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdm_host_model (
   input wire logic clk_i,
   output var sdm_pkg::sdm_io_s io_o
);
   import sdm_pkg::*;
   initial io_o = '0;
   // One access per call; the strobe stays up until the next call or idle
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (wr && a == ADDR_MASK_GROUP) v[7:4] = 4'h0;
      @(posedge clk_i);
      #1;
      io_o = {wr, ~wr, a, v};
   endtask : acc
   // Released bus shows inverted leftovers, never a stale copy
   task automatic idle();
      @(posedge clk_i);
      #1;
      io_o = {2'b00, ~io_o.addr, ~io_o.wdata};
   endtask : idle
endmodule : sdm_host_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sdm_pkg::*;
   logic clk_i, reset_i, en, wide, step, rvalid, gpw, sclr;
   sdm_io_s io;
   sdm_addr_src_s s1, s2, s3;
   logic [7:0] rdata, gpd, p1, p2, p3, b;
   logic [15:0] gpa;
   logic [3:0] msk;
   logic [27:0] a1, a2, a3;
   int error_cnt, samples_checked, clr_due;
   logic [7:0] rq[$];
   logic [7:0] gq[$];
   sdm_host_model i_host (.clk_i(clk_i), .io_o(io));
   sdm_regs i_dut (.clk_i(clk_i), .reset_i(reset_i), .io_i(io), .rdata_o(rdata),
      .rvalid_o(rvalid), .gp_wr_o(gpw), .gp_addr_o(gpa), .gp_data_o(gpd),
      .chan_mask_o(msk), .slave_clear_o(sclr), .ch1_src_i(s1), .ch2_src_i(s2),
      .ch3_src_i(s3), .enhanced_feature_on_i(en), .chan3_wide_select_i(wide),
      .page_step_i(step), .ch1_addr_o(a1), .ch2_addr_o(a2), .ch3_addr_o(a3));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("errors=%0d checks=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_host.acc(1'b1, a, d);
      if (a == ADDR_POST) gq.push_back(d);
      if (a == ADDR_SCRATCH) clr_due++;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      rq.push_back(e);
      i_host.acc(1'b0, a, 8'h00);
   endtask : rd
   task automatic settle();
      i_host.idle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic pulse();
      i_host.idle();
      step = 1'b1;
      @(posedge clk_i);
      #1;
      step = 1'b0;
   endtask : pulse
   // Negedge sampling keeps clear of the launching edge
   always @(negedge clk_i) begin
      if (rvalid === 1'b1) chk(rdata, rq.pop_front());
      if (gpw === 1'b1) chk(gq.size() > 0, 1);
      if (gpw === 1'b1) chk({gpa, gpd}, {ADDR_POST, gq.pop_front()});
      if (sclr === 1'b1) chk(clr_due > 0, 1);
      if (sclr === 1'b1) clr_due--;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
   initial begin
      reset_i = 1'b1;
      {en, wide, step} = 3'b000;
      {s1, s2, s3} = '0;
      error_cnt = 0;
      samples_checked = 0;
      clr_due = 0;
      void'($urandom(16));
      repeat (4) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      chk(msk, MASK_RESET);
      rd(ADDR_POST, BYTE_RESET);
      rd(ADDR_PAGE2, BYTE_RESET);
      rd(ADDR_PAGE3, BYTE_RESET);
      {p1, p2, p3, b} = $urandom;
      {s1, s2, s3} = 60'({$urandom, $urandom});
      wr(ADDR_POST, b);
      wr(ADDR_PAGE2, p2);
      wr(ADDR_PAGE3, p3);
      wr(ADDR_PAGE1, p1);
      rd(ADDR_POST, b);
      rd(ADDR_PAGE2, p2);
      rd(ADDR_PAGE3, p3);
      rd(ADDR_PAGE1, p1);
      settle();
      chk(a1, {s1.ext_page, p1, s1.mem_addr});
      chk(a2, {s2.ext_page, p2, s2.mem_addr});
      wide = 1'b1;
      settle();
      chk(a3, {s3.ext_page, p3, s3.mem_addr});
      en = 1'b1;
      settle();
      chk(a3, {s3.ext_page, p3[7:1], s3.mem_addr[0], s3.mem_addr[15:1], 1'b0});
      pulse();
      p3 = p3 + 8'h02;
      rd(ADDR_PAGE3, p3);
      wide = 1'b0;
      pulse();
      p3 = p3 + 8'h01;
      rd(ADDR_PAGE3, p3);
      wr(ADDR_MASK_GROUP, 8'hA5);
      settle();
      chk(msk, 4'h5);
      wr(ADDR_MASK_CLEAR, 8'($urandom));
      settle();
      chk(msk, 4'h0);
      wr(ADDR_SINGLE_MASK, 8'h06);
      settle();
      chk(msk, 4'h4);
      rd(ADDR_MASK_GROUP, 8'h00);
      b = 8'($urandom);
      wr(ADDR_SCRATCH, b);
      settle();
      chk(msk, MASK_RESET);
      rd(ADDR_SCRATCH, b);
      settle();
      chk(rq.size() + gq.size() + clr_due, 0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
